// file: sar_seq_pkg.sv
// constants, register map and state encoding of the conversion sequencer
// assumes a single 200 MHz system clock and a 32-bit avalon-mm register port
package sar_seq_pkg;

  // ---------------------------------------------------------------------
  // data path
  // ---------------------------------------------------------------------
  localparam int RES_BITS = 8;
  localparam int CHAN_BITS = 3;
  localparam int CHAN_COUNT = 8;
  localparam logic [2:0] MSB_INDEX = 3'h7;
  localparam logic [2:0] LSB_INDEX = 3'h0;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int CONV_FREQ_KHZ = 640;
  // round down so the conversion clock never runs slower than asked
  localparam int CONV_DIV_CYCLES = CLK_FREQ_KHZ / CONV_FREQ_KHZ;
  localparam int DIV_BITS = 16;

  // ---------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam int ADDR_BITS = 4;
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] RESULT_ADDR = 4'h8;
  localparam logic [3:0] DIV_ADDR = 4'hc;

  // control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_LOOP_BIT = 1;
  // status fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_ABORT_BIT = 2;
  localparam int STAT_CHAN_LSB = 4;

  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [2:0] CHAN_RESET = 3'h0;

  // ---------------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_CONVERT = 2'b10,
    ST_FINISH = 2'b11
  } seq_state_t;

endpackage : sar_seq_pkg

// file: sar_conversion_sequencer.sv
// control logic of an 8-bit successive-approximation converter with
// an 8-way input selector and avalon-mm registers
// assumes the ladder and comparator sit outside: this block drives the
// trial code and reads back one comparator bit through a synchroniser
//
// How it works
// - the result is positive-true binary, a high bit means its weight is in the code.
// - each conversion runs exactly eight approximation steps, one per result bit.
// - a rising edge on the start input clears the approximation register.
// - the approximation steps begin only once the start input falls again.
// - a start pulse during a conversion abandons it and restarts from a cleared register.
// - free-running mode feeds the done output back into start so each end starts the next.
// - done goes low between 0 and 8 conversion-clock periods after start rises.
// - codes step first at half an lsb above the bottom reference, then every lsb.
// - the result register updates one conversion-clock period before done rises.
// - the channel code is captured on the rising edge of the channel latch strobe.
// - the latched code, c line as msb, selects input 0 to 7 in binary order.
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/100ps

module sar_conversion_sequencer #(
  parameter int RES_W = sar_seq_pkg::RES_BITS,
  parameter int DIV_DEFAULT = sar_seq_pkg::CONV_DIV_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // avalon-mm register port
  input wire logic [sar_seq_pkg::ADDR_BITS-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // converter pins
  input wire logic start_conversion_pulse_i,
  input wire logic chan_latch_i,
  input wire logic [sar_seq_pkg::CHAN_BITS-1:0] chan_addr_i,
  input wire logic result_oe_req_i,
  output logic eoc_o,
  output logic [RES_W-1:0] result_o,
  output logic result_oe_o,
  // analog side
  input wire logic comparator_i,
  output logic [RES_W-1:0] approximation_register_o,
  output logic [sar_seq_pkg::CHAN_COUNT-1:0] analog_input_sel_o
);

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  localparam int SYNC_W = 4 + sar_seq_pkg::CHAN_BITS;

  logic [SYNC_W-1:0] pin_meta_r;
  logic [SYNC_W-1:0] pin_sync_r;
  wire logic [SYNC_W-1:0] pin_raw = {start_conversion_pulse_i, chan_latch_i, result_oe_req_i,
                                     comparator_i, chan_addr_i};

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else
    begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  wire logic start_pin = pin_sync_r[SYNC_W-1];
  wire logic latch_pin = pin_sync_r[SYNC_W-2];
  wire logic oe_pin = pin_sync_r[SYNC_W-3];
  wire logic comp_pin = pin_sync_r[SYNC_W-4];
  wire logic [sar_seq_pkg::CHAN_BITS-1:0] chan_pin = pin_sync_r[sar_seq_pkg::CHAN_BITS-1:0];

  // ---------------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------------
  logic wait_r;
  logic [31:0] rdata_r;
  logic loop_en_r;
  logic sw_start_r;
  logic abort_r;
  logic [sar_seq_pkg::DIV_BITS-1:0] div_r;

  // a request is answered in the second cycle it is held; that edge commits it
  wire logic req = read_i | write_i;
  wire logic wait_nxt = ~(req & wait_r);
  wire logic commit = req & ~wait_r;
  wire logic wr_commit = write_i & ~wait_r;
  wire logic hit_ctrl = address_i == sar_seq_pkg::CTRL_ADDR;
  wire logic hit_stat = address_i == sar_seq_pkg::STATUS_ADDR;
  wire logic hit_res = address_i == sar_seq_pkg::RESULT_ADDR;
  wire logic hit_div = address_i == sar_seq_pkg::DIV_ADDR;
  wire logic wr_ctrl = wr_commit & hit_ctrl;
  wire logic wr_stat = wr_commit & hit_stat;
  wire logic wr_div = wr_commit & hit_div;

  // ---------------------------------------------------------------------
  // conversion clock
  // ---------------------------------------------------------------------
  logic [sar_seq_pkg::DIV_BITS-1:0] div_cnt_r;
  // a zero divider would stop the sequencer, so it acts as one
  wire logic conv_tick = (div_cnt_r == '0);
  wire logic [sar_seq_pkg::DIV_BITS-1:0] div_load = (div_r == '0) ? '0 : div_r - 1'b1;

  // ---------------------------------------------------------------------
  // start detection
  // ---------------------------------------------------------------------
  sar_seq_pkg::seq_state_t state_r;
  logic start_q_r;
  logic eoc_r;

  // done only reaches start when the loop is enabled, and done leaves reset
  // low, so the loop needs one outside pulse to get going
  wire logic loop_start = loop_en_r & eoc_r;
  wire logic start_level = start_pin | sw_start_r | loop_start;
  wire logic start_rise = start_level & ~start_q_r;
  wire logic start_fall = ~start_level & start_q_r;
  wire logic busy = state_r != sar_seq_pkg::ST_IDLE;
  wire logic abort_evt = start_rise & (state_r == sar_seq_pkg::ST_CONVERT);
  // restart the divider as the steps begin, so the first trial is shown a
  // full period before the comparator is sampled; the divider must be at
  // least 3 to cover the comparator synchroniser
  wire logic conv_begin = start_fall & (state_r == sar_seq_pkg::ST_ARMED);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      div_cnt_r <= '0;
    else
      div_cnt_r <= (conv_tick | conv_begin) ? div_load : div_cnt_r - 1'b1;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      start_q_r <= 1'b0;
    else
      start_q_r <= start_level;
  end

  // ---------------------------------------------------------------------
  // approximation sequencer
  // ---------------------------------------------------------------------
  logic [RES_W-1:0] sar_r;
  logic [2:0] bit_r;
  logic [RES_W-1:0] result_r;

  // the ladder adds half an lsb below the trial level, so a kept bit means
  // the input is at or above that step; the code itself is the trial
  wire logic [RES_W-1:0] trial_bit = {{(RES_W-1){1'b0}}, 1'b1} << bit_r;
  wire logic [RES_W-1:0] next_bit = trial_bit >> 1;
  wire logic [RES_W-1:0] decided = comp_pin ? sar_r : (sar_r & ~trial_bit);
  wire logic last_step = bit_r == sar_seq_pkg::LSB_INDEX;

  sar_seq_pkg::seq_state_t state_nxt;
  logic [RES_W-1:0] sar_nxt;
  logic [2:0] bit_nxt;
  logic eoc_nxt;
  logic [RES_W-1:0] result_nxt;

  always_comb
  begin
    state_nxt = state_r;
    sar_nxt = sar_r;
    bit_nxt = bit_r;
    eoc_nxt = eoc_r;
    result_nxt = result_r;
    if (start_rise)
    begin
      // clear at once and pull done low in the same cycle, so the low
      // comes zero conversion-clock periods after start rises
      sar_nxt = '0;
      eoc_nxt = 1'b0;
      state_nxt = sar_seq_pkg::ST_ARMED;
    end
    else
    begin
      case (state_r)
        sar_seq_pkg::ST_ARMED:
        begin
          if (start_fall)
          begin
            // steps start only after start has dropped
            sar_nxt = {1'b1, {(RES_W-1){1'b0}}};
            bit_nxt = sar_seq_pkg::MSB_INDEX;
            state_nxt = sar_seq_pkg::ST_CONVERT;
          end
        end
        sar_seq_pkg::ST_CONVERT:
        begin
          if (conv_tick)
          begin
            // one decision per conversion-clock period, eight in all
            sar_nxt = decided | next_bit;
            bit_nxt = bit_r - 3'h1;
            if (last_step)
            begin
              sar_nxt = decided;
              // result lands one period ahead of done
              result_nxt = decided;
              state_nxt = sar_seq_pkg::ST_FINISH;
            end
          end
        end
        sar_seq_pkg::ST_FINISH:
        begin
          if (conv_tick)
          begin
            eoc_nxt = 1'b1;
            state_nxt = sar_seq_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_nxt = sar_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r <= sar_seq_pkg::ST_IDLE;
      sar_r <= sar_seq_pkg::RESULT_RESET;
      bit_r <= sar_seq_pkg::MSB_INDEX;
      eoc_r <= 1'b0;
      result_r <= sar_seq_pkg::RESULT_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      sar_r <= sar_nxt;
      bit_r <= bit_nxt;
      eoc_r <= eoc_nxt;
      result_r <= result_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // channel latch and selector
  // ---------------------------------------------------------------------
  logic latch_q_r;
  logic [sar_seq_pkg::CHAN_BITS-1:0] chan_r;
  logic [sar_seq_pkg::CHAN_COUNT-1:0] sel_r;
  wire logic latch_rise = latch_pin & ~latch_q_r;
  logic [sar_seq_pkg::CHAN_COUNT-1:0] sel_nxt;

  // code bit 2 is the c line, so input n is picked by binary n
  for (genvar g = 0; g < sar_seq_pkg::CHAN_COUNT; g++)
  begin : g_sel
    assign sel_nxt[g] = chan_r == (sar_seq_pkg::CHAN_BITS)'(g);
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      latch_q_r <= 1'b0;
      chan_r <= sar_seq_pkg::CHAN_RESET;
      sel_r <= '0;
    end
    else
    begin
      latch_q_r <= latch_pin;
      if (latch_rise)
        chan_r <= chan_pin;
      sel_r <= sel_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------------
  logic [31:0] rdata_nxt;
  wire logic [31:0] ctrl_word = {30'h0, loop_en_r, 1'b0};
  wire logic [31:0] stat_word = {25'h0, chan_r, 1'b0, abort_r, busy, eoc_r};
  wire logic [31:0] res_word = {{(32-RES_W){1'b0}}, result_r};
  wire logic [31:0] div_word = {{(32-sar_seq_pkg::DIV_BITS){1'b0}}, div_r};

  always_comb
  begin
    if (hit_ctrl)
      rdata_nxt = ctrl_word;
    else if (hit_stat)
      rdata_nxt = stat_word;
    else if (hit_res)
      rdata_nxt = res_word;
    else if (hit_div)
      rdata_nxt = div_word;
    else
      rdata_nxt = 32'h0000_0000;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      loop_en_r <= 1'b0;
      sw_start_r <= 1'b0;
      abort_r <= 1'b0;
      div_r <= sar_seq_pkg::DIV_BITS'(DIV_DEFAULT);
    end
    else
    begin
      wait_r <= wait_nxt;
      if (read_i & wait_r)
        rdata_r <= rdata_nxt;
      // a one-cycle pulse gives the sequencer both a rising and a falling edge
      sw_start_r <= wr_ctrl & writedata_i[sar_seq_pkg::CTRL_START_BIT];
      if (wr_ctrl)
        loop_en_r <= writedata_i[sar_seq_pkg::CTRL_LOOP_BIT];
      if (wr_div)
        div_r <= writedata_i[sar_seq_pkg::DIV_BITS-1:0];
      // a new abort wins over a write-one-to-clear in the same cycle
      if (abort_evt)
        abort_r <= 1'b1;
      else if (wr_stat & writedata_i[sar_seq_pkg::STAT_ABORT_BIT])
        abort_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  logic oe_r;
  logic [RES_W-1:0] result_pin_r;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      oe_r <= 1'b0;
      result_pin_r <= sar_seq_pkg::RESULT_RESET;
    end
    else
    begin
      oe_r <= oe_pin;
      // no inversion on the way out: high means the weight is present
      result_pin_r <= result_nxt;
    end
  end

  assign readdata_o = rdata_r;
  assign waitrequest_o = wait_r;
  assign eoc_o = eoc_r;
  assign result_o = result_pin_r;
  assign result_oe_o = oe_r;
  assign approximation_register_o = sar_r;
  assign analog_input_sel_o = sel_r;

endmodule : sar_conversion_sequencer

// file: analog_front_model.sv
// behavioural selector, ladder and comparator facing the sequencer
// assumes the bench loads one 8-bit level per channel, in lsb units
`timescale 1ns/100ps

module analog_front_model (
  // channel n level in bits 8n+7:8n
  input wire logic [63:0] level_i,
  // from the sequencer
  input wire logic [7:0] sel_i,
  input wire logic [7:0] trial_i,
  // to the sequencer
  output logic cmp_o
);
  logic [7:0] lvl;

  // one-hot selector picks channel n by bit n
  always_comb
  begin
    lvl = 8'h00;
    for (int n = 0; n < 8; n++)
      if (sel_i[n]) lvl = level_i[8*n +: 8];
  end

  // integer levels sit half an lsb past each step, so at-or-above is exact
  assign cmp_o = (lvl >= trial_i);
endmodule : analog_front_model

// file: sar_seq_asserts.sv
// port checker of the conversion sequencer
// assumes a bind onto every sequencer instance, single clock domain
`timescale 1ns/100ps

module sar_seq_asserts #(
  parameter int RES_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [sar_seq_pkg::ADDR_BITS-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  // converter pins
  input wire logic start_conversion_pulse_i,
  input wire logic result_oe_req_i,
  input wire logic eoc_o,
  input wire logic [RES_W-1:0] result_o,
  input wire logic result_oe_o,
  input wire logic [RES_W-1:0] approximation_register_o,
  input wire logic [sar_seq_pkg::CHAN_COUNT-1:0] analog_input_sel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence start_seen_s;
    $rose(start_conversion_pulse_i) ##1 start_conversion_pulse_i [*2];
  endsequence
  sequence cleared_s;
    approximation_register_o == '0 && !eoc_o;
  endsequence

  one_wait_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("access not answered after one wait cycle");
  unmapped_zero_a: assert property (read_i && waitrequest_o && address_i[1:0] != 2'h0
    |=> readdata_o == 32'h0) else $error("unmapped read not zero");
  sel_onehot_a: assert property ($past(rstn_i) |-> $onehot(analog_input_sel_o))
    else $error("selector not one-hot");
  start_clear_a: assert property (start_seen_s |-> ##[0:3] cleared_s)
    else $error("start rise did not clear and drop done");
  hold_zero_a: assert property (start_conversion_pulse_i [*4] |-> cleared_s)
    else $error("approximation ran while start high");
  first_trial_a: assert property ($fell(start_conversion_pulse_i)
    |-> ##[1:8] approximation_register_o == {1'b1, {(RES_W-1){1'b0}}})
    else $error("first trial not msb");
  done_hold_a: assert property ($past(eoc_o) && eoc_o
    |-> $stable(result_o) && $stable(approximation_register_o))
    else $error("result moved while done");
  oe_lag_a: assert property ($past(rstn_i, 3) |-> result_oe_o == $past(result_oe_req_i, 3))
    else $error("output enable lag wrong");
endmodule : sar_seq_asserts

bind sar_conversion_sequencer sar_seq_asserts #(.RES_W(RES_W)) u_asserts (
  .clk_i(clk_i), .rstn_i(rstn_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
  .start_conversion_pulse_i(start_conversion_pulse_i), .result_oe_req_i(result_oe_req_i),
  .eoc_o(eoc_o), .result_o(result_o), .result_oe_o(result_oe_o),
  .approximation_register_o(approximation_register_o),
  .analog_input_sel_o(analog_input_sel_o));

// file: sar_conversion_sequencer_tb_top.sv
// self-checking bench of the conversion sequencer
// assumes the bound checker and the analog model on the converter pins
`timescale 1ns/100ps

module sar_conversion_sequencer_tb_top;
  logic clk_i, rstn_i, read_i, write_i, start_i, latch_i, oe_req_i, cmp, wreq, eoc, oe;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [2:0] chan;
  logic [63:0] level;
  logic [7:0] result, approx, sel;
  int fails, n_checks;

  sar_conversion_sequencer i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .address_i(addr),
    .read_i(read_i), .write_i(write_i), .writedata_i(wdata), .readdata_o(rdata),
    .waitrequest_o(wreq), .start_conversion_pulse_i(start_i), .chan_latch_i(latch_i),
    .chan_addr_i(chan), .result_oe_req_i(oe_req_i), .eoc_o(eoc), .result_o(result),
    .result_oe_o(oe), .comparator_i(cmp), .approximation_register_o(approx),
    .analog_input_sel_o(sel));
  analog_front_model i_front (.level_i(level), .sel_i(sel), .trial_i(approx), .cmp_o(cmp));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // one access; waits for waitrequest low, then one idle edge
  task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    read_i <= !wr;
    write_i <= wr;
    wdata <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wreq !== 1'b0 && n < 20);
    q = rdata;
    read_i <= 1'b0;
    write_i <= 1'b0;
    if (wreq !== 1'b0) fails++;
    if (wreq !== 1'b0) report_and_stop();
    @(posedge clk_i);
  endtask : bus

  task automatic wait_eoc(input logic lvl);
    int n;
    n = 0;
    while (eoc !== lvl && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (eoc !== lvl) fails++;
    if (eoc !== lvl) report_and_stop();
  endtask : wait_eoc

  task automatic start_pin();
    start_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    check(eoc, 1'b0);
    check(approx, 8'h00);
    start_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : start_pin

  function automatic logic [7:0] expect_code(input logic [7:0] lvl);
    logic [7:0] c;
    c = 8'h00;
    for (int b = 7; b >= 0; b--)
      if (lvl >= (c | (8'h01 << b))) c = c | (8'h01 << b);
    return c;
  endfunction : expect_code

  // latch a channel, move the address away, then convert it
  task automatic convert(input logic [2:0] ch, input logic [7:0] v);
    level[8*ch +: 8] <= v;
    chan <= ch;
    repeat (4) @(posedge clk_i);
    latch_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    latch_i <= 1'b0;
    chan <= ~ch;
    repeat (4) @(posedge clk_i);
    check(sel, 8'h01 << ch);
    start_pin();
    wait_eoc(1'b1);
    check(result, expect_code(v));
    bus(4'h8, 1'b0, 32'h0);
    check(q, {24'h0, expect_code(v)});
  endtask : convert

  initial
  begin
    {rstn_i, read_i, write_i, start_i, latch_i, oe_req_i} = 6'h00;
    {addr, wdata, chan, level, fails, n_checks} = '0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    void'($urandom(74544));
    bus(4'h4, 1'b0, 32'h0);
    check(q, 32'h0);
    bus(4'hc, 1'b0, 32'h0);
    check(q, 32'(sar_seq_pkg::CONV_DIV_CYCLES));
    bus(4'h6, 1'b0, 32'h0);
    check(q, 32'h0);
    bus(4'hc, 1'b1, 32'h4);
    bus(4'h8, 1'b1, 32'h5a);
    for (int ch = 0; ch < 8; ch++)
      convert(3'(ch), (ch == 0) ? 8'h00 : (ch == 7) ? 8'hff : 8'($urandom));
    // restart in mid-conversion with a new level
    start_pin();
    repeat (8) @(posedge clk_i);
    level[63:56] <= 8'h3c;
    start_pin();
    wait_eoc(1'b1);
    check(result, 8'h3c);
    bus(4'h4, 1'b0, 32'h0);
    check(q[2:0], 3'b101);
    bus(4'h4, 1'b1, 32'h4);
    bus(4'h4, 1'b0, 32'h0);
    check(q[2:0], 3'b001);
    level[63:56] <= 8'h81;
    bus(4'h0, 1'b1, 32'h1);
    wait_eoc(1'b0);
    wait_eoc(1'b1);
    check(result, 8'h81);
    oe_req_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    check(oe, 1'b1);
    oe_req_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    check(oe, 1'b0);
    // free-running: one outside pulse, then done restarts itself
    bus(4'h0, 1'b1, 32'h2);
    level[63:56] <= 8'h01;
    start_pin();
    repeat (2)
    begin
      wait_eoc(1'b1);
      check(result, 8'h01);
      wait_eoc(1'b0);
    end
    bus(4'h0, 1'b1, 32'h0);
    report_and_stop();
  end
endmodule : sar_conversion_sequencer_tb_top
